// ===== core/rmx_dev.sv
// switch side of the third port: reduced di-bit and 7-wire serial modes
// assumes CLK user domain, link logic on the reference clock of LINK
//
// Overview of operation
// - reduced mode runs at 10 or 100 Mbps
// - one external 50 MHz reference, input only
// - separate two-bit transmit and receive paths
// - device drives receive valid and data bits
// - no receive error output in reduced mode
// - phy receive error enters transmit error input
// - reduced collision from valid and transmit enable
// - far side ties upper data low, drives error from SEND_ERR
// - works facing phy or another mac
// - serial mode: device is phy, partner mac
// - serial data one bit on bit zero
// - enable marks transmit data, valid is carrier
// - half duplex serial collision output asserted
module rmx_afifo #(
  parameter int W = 19,
  parameter int DEPTH = 4
) (
  input wire logic wclk,
  input wire logic wrst,
  input wire logic w_valid,
  output logic w_ready,
  input wire logic [W-1:0] w_data,
  input wire logic rclk,
  input wire logic rrst,
  output logic r_valid,
  input wire logic r_ready,
  output logic [W-1:0] r_data
);
  import rmx_pkg::*;
  // gray pointers; depth must be a power of two, four or more
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW:0] bin;
    logic [AW:0] gray;
    logic [AW:0] s1;
    logic [AW:0] s2;
  } rmx_wside_t;
  typedef struct packed {
    logic [AW:0] bin;
    logic [AW:0] gray;
    logic [AW:0] s1;
    logic [AW:0] s2;
  } rmx_rside_t;
  rmx_wside_t w_r, w_nxt;
  rmx_rside_t r_r, r_nxt;

  assign w_ready = (w_r.gray != {~w_r.s2[AW:AW-1], w_r.s2[AW-2:0]});
  assign r_valid = (r_r.gray != r_r.s2);
  assign r_data = w_r.mem[r_r.bin[AW-1:0]];

  always_comb begin
    w_nxt = w_r;
    w_nxt.s1 = r_r.gray;
    w_nxt.s2 = w_r.s1;
    if (w_valid && w_ready) begin
      w_nxt.mem[w_r.bin[AW-1:0]] = w_data;
      w_nxt.bin = w_r.bin + 1'b1;
      w_nxt.gray = w_nxt.bin ^ (w_nxt.bin >> 1);
    end
    if (wrst) begin
      w_nxt = '0;
    end
  end

  always_comb begin
    r_nxt = r_r;
    r_nxt.s1 = w_r.gray;
    r_nxt.s2 = r_r.s1;
    if (r_valid && r_ready) begin
      r_nxt.bin = r_r.bin + 1'b1;
      r_nxt.gray = r_nxt.bin ^ (r_nxt.bin >> 1);
    end
    if (rrst) begin
      r_nxt = '0;
    end
  end

  always_ff @(posedge wclk) begin
    w_r <= w_nxt;
  end

  always_ff @(posedge rclk) begin
    r_r <= r_nxt;
  end
endmodule

////////////////////////////////////////////////////////////////////////////////

module rmx_dev (
  input wire logic CLK,
  input wire logic RST,
  rmx_link_if.dev LINK,
  input wire rmx_pkg::rmx_mode_t MODE,
  input wire logic SPEED_100,
  input wire logic HALF_DUPLEX,
  input wire logic SEND_VALID,
  output logic SEND_READY,
  input wire logic [rmx_pkg::WORD_W-1:0] SEND_DATA,
  input wire logic SEND_LAST,
  input wire logic SEND_HALF,
  output logic RECV_VALID,
  input wire logic RECV_READY,
  output logic [rmx_pkg::WORD_W-1:0] RECV_DATA,
  output logic RECV_LAST,
  output logic RECV_HALF,
  output logic RECV_ERR,
  output logic COLLISION
);
  import rmx_pkg::*;
  typedef struct packed {
    logic rs1;
    logic rs2;
    logic [2:0] cf1;
    logic [2:0] cf2;
    logic [3:0] tcnt;
    logic bclk;
    logic r_act;
    logic [4:0] r_cnt;
    logic [WORD_W-1:0] r_sh;
    logic r_err;
    logic push;
    logic [ENTRY_W-1:0] push_d;
    logic [4:0] t_bits;
    logic [WORD_W-1:0] t_sh;
    logic t_last;
    logic dv;
    logic [1:0] dout;
    logic col;
    logic col_pin;
  } rmx_lnk_t;
  typedef struct packed {
    logic c1;
    logic c2;
  } rmx_sys_t;
  rmx_lnk_t l_r, l_nxt;
  rmx_sys_t s_r, s_nxt;
  logic lclk;
  logic sni, spd, hd, tick, out_pop;
  logic [3:0] per;
  logic [4:0] cnt0, wb;
  logic [WORD_W-1:0] ws;
  logic wl;
  logic in_wrdy, out_rv;
  logic [ENTRY_W-1:0] out_rd, in_rd;

  // reference clock only ever sampled, never driven
  assign lclk = LINK.reference_clock_in;
  assign sni = l_r.cf2[0];
  assign spd = l_r.cf2[1];
  assign hd = l_r.cf2[2];

  ////////////////////////////////////////////////////////////////////////////
  // link domain

  always_comb begin
    l_nxt = l_r;
    out_pop = 1'b0;
    ws = l_r.t_sh;
    wb = l_r.t_bits;
    wl = l_r.t_last;
    cnt0 = l_r.r_cnt;
    per = sni ? SNI_M1 : (spd ? FAST_M1 : SLOW_M1);
    tick = (l_r.tcnt == 4'h0);
    l_nxt.tcnt = tick ? per : l_r.tcnt - 4'h1;
    l_nxt.bclk = sni && (l_nxt.tcnt <= SNI_HALF);
    l_nxt.push = 1'b0;
    l_nxt.col = hd && l_r.dv && LINK.tx_enable_in;
    l_nxt.col_pin = l_nxt.col && sni;
    // no link back-pressure: a word the fifo cannot take marks the frame bad
    if (l_r.push && !in_wrdy) begin
      l_nxt.r_err = 1'b1;
    end
    if (tick) begin
      if (LINK.tx_enable_in) begin
        if (l_r.r_cnt == BITS_WORD) begin
          l_nxt.push = 1'b1;
          l_nxt.push_d = '0;
          l_nxt.push_d[WORD_W-1:0] = l_r.r_sh;
          l_nxt.push_d[E_ERR] = l_r.r_err;
          cnt0 = 5'h00;
        end
        if (sni) begin
          l_nxt.r_sh = {LINK.tx_data_in[0], l_r.r_sh[WORD_W-1:1]};
          l_nxt.r_cnt = cnt0 + 5'h01;
        end else begin
          l_nxt.r_sh = {LINK.tx_data_in[1:0], l_r.r_sh[WORD_W-1:2]};
          l_nxt.r_cnt = cnt0 + 5'h02;
        end
        l_nxt.r_act = 1'b1;
        l_nxt.r_err = l_nxt.r_err | LINK.rx_error_in;
      end else if (l_r.r_act) begin
        l_nxt.r_act = 1'b0;
        l_nxt.r_cnt = 5'h00;
        l_nxt.r_err = 1'b0;
        if (l_r.r_cnt != 5'h00) begin
          l_nxt.push = 1'b1;
          l_nxt.push_d = '0;
          l_nxt.push_d[E_LAST] = 1'b1;
          l_nxt.push_d[E_HALF] = (l_r.r_cnt <= BITS_HALF);
          l_nxt.push_d[E_ERR] = l_r.r_err
            | ((l_r.r_cnt != BITS_HALF) && (l_r.r_cnt != BITS_WORD));
          l_nxt.push_d[WORD_W-1:0] = (l_r.r_cnt <= BITS_HALF)
            ? {8'h00, l_r.r_sh[WORD_W-1:BYTE_W]} : l_r.r_sh;
        end
      end
      // one idle symbol after a last word keeps frames apart
      if (wb == 5'h00 && !wl && out_rv) begin
        out_pop = 1'b1;
        ws = out_rd[WORD_W-1:0];
        wb = out_rd[E_HALF] ? BITS_HALF : BITS_WORD;
        wl = out_rd[E_LAST];
      end
      if (wb != 5'h00) begin
        l_nxt.dv = 1'b1;
        if (sni) begin
          l_nxt.dout = {1'b0, ws[0]};
          ws = ws >> 1;
          wb = wb - 5'h01;
        end else begin
          l_nxt.dout = ws[1:0];
          ws = ws >> 2;
          wb = wb - 5'h02;
        end
      end else begin
        l_nxt.dv = 1'b0;
        l_nxt.dout = 2'h0;
        wl = 1'b0;
      end
      l_nxt.t_sh = ws;
      l_nxt.t_bits = wb;
      l_nxt.t_last = wl;
    end
    if (l_r.rs2) begin
      l_nxt = '0;
    end
    l_nxt.rs1 = RST;
    l_nxt.rs2 = l_r.rs1;
    l_nxt.cf1 = {HALF_DUPLEX, SPEED_100, MODE == RMX_SNI};
    l_nxt.cf2 = l_r.cf1;
  end

  always_ff @(posedge lclk) begin
    l_r <= l_nxt;
  end

  // receive error deliberately absent: bad received frames reach the user flagged on RECV_ERR
  assign LINK.rx_valid_out = l_r.dv;
  assign LINK.rx_data_out = l_r.dout;
  assign LINK.collision_out = l_r.col_pin;
  assign LINK.tx_bit_clock = l_r.bclk;
  assign LINK.rx_bit_clock = l_r.bclk;

  ////////////////////////////////////////////////////////////////////////////
  // user domain

  always_comb begin
    s_nxt.c1 = l_r.col;
    s_nxt.c2 = s_r.c1;
    if (RST) begin
      s_nxt = '0;
    end
  end

  always_ff @(posedge CLK) begin
    s_r <= s_nxt;
  end

  assign COLLISION = s_r.c2;

  rmx_afifo #(
    .W(ENTRY_W),
    .DEPTH(FIFO_DEPTH)
  ) u_in_fifo (
    .wclk(lclk),
    .wrst(l_r.rs2),
    .w_valid(l_r.push),
    .w_ready(in_wrdy),
    .w_data(l_r.push_d),
    .rclk(CLK),
    .rrst(RST),
    .r_valid(RECV_VALID),
    .r_ready(RECV_READY),
    .r_data(in_rd)
  );

  assign RECV_DATA = in_rd[WORD_W-1:0];
  assign RECV_LAST = in_rd[E_LAST];
  assign RECV_HALF = in_rd[E_HALF];
  assign RECV_ERR = in_rd[E_ERR];

  rmx_afifo #(
    .W(ENTRY_W),
    .DEPTH(FIFO_DEPTH)
  ) u_out_fifo (
    .wclk(CLK),
    .wrst(RST),
    .w_valid(SEND_VALID),
    .w_ready(SEND_READY),
    .w_data({1'b0, SEND_HALF, SEND_LAST, SEND_DATA}),
    .rclk(lclk),
    .rrst(l_r.rs2),
    .r_valid(out_rv),
    .r_ready(out_pop),
    .r_data(out_rd)
  );
endmodule

// ===== pkg/rmx_pkg.sv
// constants and types shared by both ends of the reduced / serial link
// assumes a link reference clock of REF_CLK_MHZ and a user clock on the device end only
package rmx_pkg;
  localparam int REF_CLK_MHZ = 50;
  localparam int RATE_LO_MBPS = 10;
  localparam int RATE_HI_MBPS = 100;
  localparam int SYM_W = 2;
  localparam int TXD_W = 4;
  // reference cycles per di-bit at each rate, and per serial bit
  localparam int SLOW_HOLD = REF_CLK_MHZ * SYM_W / RATE_LO_MBPS;
  localparam int FAST_HOLD = REF_CLK_MHZ * SYM_W / RATE_HI_MBPS;
  localparam int SNI_DIV = REF_CLK_MHZ / RATE_LO_MBPS;
  localparam logic [3:0] SLOW_M1 = 4'(SLOW_HOLD - 1);
  localparam logic [3:0] FAST_M1 = 4'(FAST_HOLD - 1);
  localparam logic [3:0] SNI_M1 = 4'(SNI_DIV - 1);
  localparam logic [3:0] SNI_HALF = 4'(SNI_DIV / 2);
  localparam int WORD_W = 16;
  localparam int BYTE_W = 8;
  localparam logic [4:0] BITS_WORD = 5'h10;
  localparam logic [4:0] BITS_HALF = 5'h08;
  localparam logic [3:0] BITS_BYTE = 4'h8;
  // fifo entry: {err, half, last, data}
  localparam int E_LAST = 16;
  localparam int E_HALF = 17;
  localparam int E_ERR = 18;
  localparam int ENTRY_W = 19;
  localparam int FIFO_DEPTH = 4;
  typedef enum logic {
    RMX_RMII = 1'b0,
    RMX_SNI = 1'b1
  } rmx_mode_t;
endpackage

// ===== pkg/rmx_link_if.sv
// link wires between the switch port and its partner
// assumes the bench drives reference_clock_in and joins both ends here
interface rmx_link_if (
  input wire logic reference_clock_in
);
  logic rx_valid_out;
  logic [1:0] rx_data_out;
  logic tx_enable_in;
  logic [3:0] tx_data_in;
  logic rx_error_in;
  logic collision_out;
  logic tx_bit_clock;
  logic rx_bit_clock;
  modport dev (
    input reference_clock_in,
    input tx_enable_in,
    input tx_data_in,
    input rx_error_in,
    output rx_valid_out,
    output rx_data_out,
    output collision_out,
    output tx_bit_clock,
    output rx_bit_clock
  );
  modport far (
    input reference_clock_in,
    output tx_enable_in,
    output tx_data_in,
    output rx_error_in,
    input rx_valid_out,
    input rx_data_out,
    input collision_out,
    input tx_bit_clock,
    input rx_bit_clock
  );
endinterface

// ===== core/rmx_far.sv
// partner end: reduced-mode mac or phy, or serial-mode mac controller
// assumes RST and all user ports are synchronous to the link reference clock
module rmx_far (
  input wire logic RST,
  rmx_link_if.far LINK,
  input wire rmx_pkg::rmx_mode_t MODE,
  input wire logic SPEED_100,
  input wire logic SEND_VALID,
  output logic SEND_READY,
  input wire logic [rmx_pkg::BYTE_W-1:0] SEND_DATA,
  input wire logic SEND_LAST,
  input wire logic SEND_ERR,
  output logic RECV_VALID,
  output logic [rmx_pkg::BYTE_W-1:0] RECV_DATA,
  output logic RECV_END,
  output logic COLLISION
);
  import rmx_pkg::*;
  typedef struct packed {
    logic [3:0] tcnt;
    logic ptx;
    logic prx;
    logic [BYTE_W-1:0] t_sh;
    logic [3:0] t_bits;
    logic t_last;
    logic t_err;
    logic en;
    logic [1:0] d;
    logic er;
    logic r_act;
    logic [BYTE_W-1:0] r_sh;
    logic [3:0] r_cnt;
    logic rv;
    logic rend;
    logic [BYTE_W-1:0] rd;
    logic col;
  } rmx_far_t;
  rmx_far_t f_r, f_nxt;
  logic sni, ctick, ttick, rtick, load;
  logic [BYTE_W-1:0] ws;
  logic [3:0] wb;

  assign sni = (MODE == RMX_SNI);

  always_comb begin
    f_nxt = f_r;
    ws = f_r.t_sh;
    wb = f_r.t_bits;
    ctick = (f_r.tcnt == 4'h0);
    f_nxt.tcnt = ctick ? (SPEED_100 ? FAST_M1 : SLOW_M1) : f_r.tcnt - 4'h1;
    f_nxt.ptx = LINK.tx_bit_clock;
    f_nxt.prx = LINK.rx_bit_clock;
    // serial bits launch and land on rising edges of device clocks
    ttick = sni ? (LINK.tx_bit_clock && !f_r.ptx) : ctick;
    rtick = sni ? (LINK.rx_bit_clock && !f_r.prx) : ctick;
    load = ttick && f_r.t_bits == 4'h0 && !f_r.t_last && SEND_VALID;
    f_nxt.rv = 1'b0;
    f_nxt.rend = 1'b0;
    f_nxt.col = sni ? LINK.collision_out : (f_r.en && LINK.rx_valid_out);
    if (ttick) begin
      if (load) begin
        ws = SEND_DATA;
        wb = BITS_BYTE;
        f_nxt.t_last = SEND_LAST;
        f_nxt.t_err = SEND_ERR;
      end
      if (wb != 4'h0) begin
        f_nxt.en = 1'b1;
        f_nxt.er = f_nxt.t_err;
        if (sni) begin
          f_nxt.d = {1'b0, ws[0]};
          ws = ws >> 1;
          wb = wb - 4'h1;
        end else begin
          f_nxt.d = ws[1:0];
          ws = ws >> 2;
          wb = wb - 4'h2;
        end
      end else begin
        f_nxt.en = 1'b0;
        f_nxt.er = 1'b0;
        f_nxt.d = 2'h0;
        f_nxt.t_last = 1'b0;
        f_nxt.t_err = 1'b0;
      end
      f_nxt.t_sh = ws;
      f_nxt.t_bits = wb;
    end
    if (rtick) begin
      if (LINK.rx_valid_out) begin
        f_nxt.r_act = 1'b1;
        if (sni) begin
          f_nxt.r_sh = {LINK.rx_data_out[0], f_r.r_sh[BYTE_W-1:1]};
          f_nxt.r_cnt = f_r.r_cnt + 4'h1;
        end else begin
          f_nxt.r_sh = {LINK.rx_data_out, f_r.r_sh[BYTE_W-1:2]};
          f_nxt.r_cnt = f_r.r_cnt + 4'h2;
        end
        if (f_nxt.r_cnt == BITS_BYTE) begin
          f_nxt.rv = 1'b1;
          f_nxt.rd = f_nxt.r_sh;
          f_nxt.r_cnt = 4'h0;
        end
      end else if (f_r.r_act) begin
        // a trailing partial byte is dropped at frame end
        f_nxt.r_act = 1'b0;
        f_nxt.r_cnt = 4'h0;
        f_nxt.rend = 1'b1;
      end
    end
    if (RST) begin
      f_nxt = '0;
    end
  end

  always_ff @(posedge LINK.reference_clock_in) begin
    f_r <= f_nxt;
  end

  assign SEND_READY = load && !RST;
  assign LINK.tx_enable_in = f_r.en;
  assign LINK.tx_data_in = {2'b00, f_r.d};
  assign LINK.rx_error_in = f_r.er;
  assign RECV_VALID = f_r.rv;
  assign RECV_DATA = f_r.rd;
  assign RECV_END = f_r.rend;
  assign COLLISION = f_r.col;
endmodule

// ===== testbench/rmx_link_chk.sv
// link checker: timing and levels of the wires between the two ends
// assumes mode, speed and duplex change only while RST is high
module rmx_link_chk (
  input wire logic reference_clock_in,
  input wire logic RST,
  input wire rmx_pkg::rmx_mode_t MODE,
  input wire logic SPEED_100,
  input wire logic HALF_DUPLEX,
  input wire logic rx_valid_out,
  input wire logic [1:0] rx_data_out,
  input wire logic tx_enable_in,
  input wire logic [3:0] tx_data_in,
  input wire logic collision_out,
  input wire logic tx_bit_clock,
  input wire logic rx_bit_clock
);
  import rmx_pkg::*;
  default clocking cb @(posedge reference_clock_in); endclocking
  default disable iff (RST);
  wire logic sni = (MODE == RMX_SNI);
  ////////////////////////////////////////
  tx_upper_low_a: assert property (tx_data_in[3:2] == 2'h0)
    else $error("upper transmit bits not low");
  col_reduced_a: assert property (!sni |-> !collision_out)
    else $error("collision wire active in reduced mode");
  col_half_a: assert property (collision_out |-> HALF_DUPLEX)
    else $error("collision wire active in full duplex");
  bitclk_idle_a: assert property (!sni |-> !tx_bit_clock && !rx_bit_clock)
    else $error("bit clocks run in reduced mode");
  bitclk_pair_a: assert property (tx_bit_clock == rx_bit_clock)
    else $error("bit clocks differ");
  // three high, two low: one serial bit per five reference cycles
  bitclk_period_a: assert property (sni && $rose(tx_bit_clock) |=>
    tx_bit_clock [*2] ##1 !tx_bit_clock [*2] ##1 tx_bit_clock)
    else $error("bit clock period wrong");
  slow_rx_hold_a: assert property (!sni && !SPEED_100 &&
    $changed({rx_valid_out, rx_data_out}) |=> $stable({rx_valid_out, rx_data_out}) [*8])
    else $error("receive di-bit held too short");
  slow_tx_hold_a: assert property (!sni && !SPEED_100 &&
    $changed({tx_enable_in, tx_data_in}) |=> $stable({tx_enable_in, tx_data_in}) [*8])
    else $error("transmit di-bit held too short");
  serial_hold_a: assert property (sni && $changed({rx_valid_out, rx_data_out})
    |=> $stable({rx_valid_out, rx_data_out}) [*4])
    else $error("serial bit held too short");
  serial_lane_a: assert property (sni |-> rx_data_out[1] == 1'b0)
    else $error("serial data off bit zero");
  cover property (!sni && !SPEED_100 && $rose(rx_valid_out));
  cover property ($rose(collision_out));
  cover property (sni && $fell(rx_valid_out));
  cover property (!sni && tx_enable_in && rx_valid_out);
endmodule

// ===== testbench/port3_rmii_sni_interface_bench.sv
// bench: switch port end and partner end joined by the link interface
// assumes package, interface and both ends are compiled before this file
module port3_rmii_sni_interface_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import rmx_pkg::*;
  localparam logic [15:0] WORDS [6] = '{16'hC3A5, 16'h1E0F, 16'h8001, 16'h7FFE, 16'h5AA5,
    16'h0096};
  logic clk, rclk, rst, spd, hd, s_valid, s_last, s_half, r_ready, f_valid, f_last, f_err;
  logic [WORD_W-1:0] s_data;
  logic [BYTE_W-1:0] f_data;
  rmx_mode_t mode;
  wire logic s_ready, r_valid, r_last, r_half, r_err, coll, f_ready, fr_valid, fr_end, f_coll;
  wire logic [WORD_W-1:0] r_data;
  wire logic [BYTE_W-1:0] fr_data;
  int n_mismatch, tests_run, stalls, n_end, col_seen, fcol_seen;
  logic [ENTRY_W-1:0] dev_q [$];
  logic [BYTE_W-1:0] far_q [$];
  ////////////////////////////////////////
  rmx_link_if link (.reference_clock_in(rclk));
  rmx_dev i_rmx_dev (.CLK(clk), .RST(rst), .LINK(link), .MODE(mode), .SPEED_100(spd),
    .HALF_DUPLEX(hd), .SEND_VALID(s_valid), .SEND_READY(s_ready), .SEND_DATA(s_data),
    .SEND_LAST(s_last), .SEND_HALF(s_half), .RECV_VALID(r_valid), .RECV_READY(r_ready),
    .RECV_DATA(r_data), .RECV_LAST(r_last), .RECV_HALF(r_half), .RECV_ERR(r_err),
    .COLLISION(coll));
  rmx_far i_rmx_far (.RST(rst), .LINK(link), .MODE(mode), .SPEED_100(spd),
    .SEND_VALID(f_valid), .SEND_READY(f_ready), .SEND_DATA(f_data), .SEND_LAST(f_last),
    .SEND_ERR(f_err), .RECV_VALID(fr_valid), .RECV_DATA(fr_data), .RECV_END(fr_end),
    .COLLISION(f_coll));
  rmx_link_chk i_chk (.reference_clock_in(rclk), .RST(rst), .MODE(mode), .SPEED_100(spd),
    .HALF_DUPLEX(hd), .rx_valid_out(link.rx_valid_out), .rx_data_out(link.rx_data_out),
    .tx_enable_in(link.tx_enable_in), .tx_data_in(link.tx_data_in),
    .collision_out(link.collision_out), .tx_bit_clock(link.tx_bit_clock),
    .rx_bit_clock(link.rx_bit_clock));
  ////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // reference clock free running, phase unrelated to the user clock
  initial begin
    rclk = 1'b0;
    #7;
    forever #24 rclk = ~rclk;
  end
  always @(posedge clk) begin
    if (rst === 1'b0 && r_valid === 1'b1 && r_ready === 1'b1) begin
      dev_q.push_back({r_err, r_half, r_last, r_data});
    end
    if (coll === 1'b1) begin
      col_seen = 1;
    end
  end
  always @(posedge rclk) begin
    if (fr_valid === 1'b1) begin
      far_q.push_back(fr_data);
    end
    if (fr_end === 1'b1) begin
      n_end++;
    end
    if (f_coll === 1'b1) begin
      fcol_seen = 1;
    end
  end
  ////////////////////////////////////////
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // request held from just after an edge until ready is seen high
  task automatic dev_send(input logic [15:0] d, input logic last, input logic half);
    int n;
    s_valid = 1'b1;
    s_data = d;
    s_last = last;
    s_half = half;
    n = 0;
    do begin
      @(negedge clk);
      if (s_ready !== 1'b1) stalls++;
      n++;
    end while (s_ready !== 1'b1 && n < 2000);
    if (n >= 2000) n_mismatch++;
    @(posedge clk);
    #1;
  endtask
  task automatic far_send(input logic [7:0] d, input logic last, input logic err);
    int n;
    f_valid = 1'b1;
    f_data = d;
    f_last = last;
    f_err = err;
    n = 0;
    do begin
      @(negedge rclk);
      n++;
    end while (f_ready !== 1'b1 && n < 2000);
    if (n >= 2000) n_mismatch++;
    @(posedge rclk);
    #1;
  endtask
  task automatic run(input rmx_mode_t m, input logic sp, input logic h, input logic e);
    int n;
    rst = 1'b1;
    mode = m;
    spd = sp;
    hd = h;
    repeat (4) @(posedge clk);
    #1;
    rst = 1'b0;
    repeat (10) @(posedge clk);
    #1;
    dev_q.delete();
    far_q.delete();
    n_end = 0;
    col_seen = 0;
    fcol_seen = 0;
    stalls = 0;
    // receive side stalled so the words wait in the buffer
    r_ready = 1'b0;
    fork
      begin
        for (int i = 0; i < 6; i++) dev_send(WORDS[i], i == 5, i == 5);
        s_valid = 1'b0;
      end
      begin
        @(posedge rclk);
        #1;
        far_send(8'h3C, 1'b0, 1'b0);
        far_send(8'h96, 1'b0, 1'b0);
        far_send(8'h71, 1'b1, e);
        f_valid = 1'b0;
      end
    join
    r_ready = 1'b1;
    n = 0;
    while ((far_q.size() < 11 || n_end < 1 || dev_q.size() < 2) && n < 3000) begin
      @(posedge clk);
      n++;
    end
    // a hung link counts against the run, not only the empty queues
    if (n >= 3000) n_mismatch++;
    #1;
    if (!(m == RMX_SNI && h)) begin
      for (int i = 0; i < 5; i++) begin
        check(far_q[2*i], WORDS[i][7:0]);
        check(far_q[2*i+1], WORDS[i][15:8]);
      end
      check(far_q[10], 8'h96);
      check(dev_q[0], {3'h0, 16'h963C});
      check(dev_q[1], {e, 2'h3, 16'h0071});
    end
    check(n_end, 1);
    check(col_seen, h);
    // both ends send at once, so the partner sees overlap in reduced mode always
    check(fcol_seen, (m == RMX_SNI) ? h : 1'b1);
    if (!sp || m == RMX_SNI) check(stalls > 0, 1);
    $display("test mode %0d speed %0d half %0d err %0d done", m, sp, h, e);
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    rst = 1'b1;
    mode = RMX_RMII;
    spd = 1'b1;
    hd = 1'b0;
    s_valid = 1'b0;
    s_data = 16'h0;
    s_last = 1'b0;
    s_half = 1'b0;
    r_ready = 1'b1;
    f_valid = 1'b0;
    f_data = 8'h0;
    f_last = 1'b0;
    f_err = 1'b0;
    n_mismatch = 0;
    tests_run = 0;
    run(RMX_RMII, 1'b1, 1'b0, 1'b0);
    run(RMX_RMII, 1'b0, 1'b0, 1'b1);
    run(RMX_RMII, 1'b0, 1'b1, 1'b0);
    run(RMX_SNI, 1'b0, 1'b0, 1'b0);
    run(RMX_SNI, 1'b0, 1'b1, 1'b0);
    summarize();
  end
  // watchdog: all five runs need well under this many user cycles
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    summarize();
  end
endmodule
